// ---- rtl/bc_sequencer_regs.sv ----
`timescale 1ns/1ps
`include "bc_seq_params.svh"

// Overview of operation
// - list pointer is read-only to host; only start, op step and jumps alter it.
// - writing start bit with controller enabled begins execution.
// - on start, pointer loads from the list start address register.
// - pointer addresses op code word then parameter word in RAM.
// - pointer updates after op code result is evaluated, before next.
// - load frame timer op loads frame time from its parameter word.
// - frame time counts down only after start frame timer op.
// - frame timer ticks every 100 us per lsb.
// - time to next message reloads from message block word 4.
// - message interval runs mid-sync to next mid-sync.
// - message timer ticks every 1 us per lsb.
// - condition codes read at shared address; writes reach flag register.
// - bit 15 is run status; upper byte shows last message results.
// - low eight flags set, cleared, toggled by host or flag op.
// - frame and message compare ops set or clear flags 1 and 0.
// - running flag sets on start bit while enable bit is one.
// - running clears on enable cleared, halt op or illegal op.
// - illegal op code pulses trap interrupt when it is enabled.
// - bits 14-13 report retries of last message; reset to zero.
// - retry encoding 00, 01, 10; value 11 never reported.
// - bit 12 set on format error, loopback failure or no response.

module bc_sequencer_regs (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic [15:0] ram_addr,
	output logic ram_rd,
	input wire logic ram_valid,
	input wire logic [15:0] ram_rdata,
	input wire logic [3:0] op_decoded,
	input wire logic [15:0] jump_target,
	input wire logic cond_true,
	input wire logic [1:0] flag_mode,
	input wire logic [7:0] flag_mask,
	input wire logic msg_done,
	input wire logic [1:0] msg_retries,
	input wire logic msg_bad,
	input wire logic [4:0] msg_results,
	input wire logic mid_sync,
	input wire logic [15:0] msg_word4,
	input wire logic trap_enable,
	output logic msg_start,
	output logic illegal_opcode_trap_irq
);
	logic [15:0] list_start_ff, nxt_list_start;
	logic [15:0] list_ptr_ff, nxt_list_ptr;
	logic [15:0] frame_ff, nxt_frame;
	logic frame_run_ff, nxt_frame_run;
	logic [15:0] next_msg_ff, nxt_next_msg;
	logic [15:0] next_msg_pend_ff, nxt_next_msg_pend;
	logic [7:0] flags_ff, nxt_flags;
	logic [7:0] upper_ff, nxt_upper;
	logic enable_ff, nxt_enable;
	logic run_ff, nxt_run;
	logic [15:0] opword_ff, nxt_opword;
	logic [15:0] param_ff, nxt_param;
	logic [15:0] rdata_ff, nxt_rdata;
	logic [15:0] ram_addr_ff, nxt_ram_addr;
	logic ram_rd_ff, nxt_ram_rd;
	logic msg_start_ff, nxt_msg_start;
	logic trap_ff, nxt_trap;
	bc_seq_pkg::seq_state_t state_ff, nxt_state;
	bc_seq_pkg::opcode_t op;
	logic frame_tick, msg_tick;
	logic [7:0] flag_src;
	logic [7:0] host_mask;
	logic host_flag_wr;
	logic start_req;

	// separate tick phases; the first start op begins the 100 us phase cleanly, later ones do not restart it
	tick_divider #(.DIV(`FRAME_TICK_CYC)) u_frame_tick (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clear(!frame_run_ff),
		.tick(frame_tick)
	);

	tick_divider #(.DIV(`MSG_TICK_CYC)) u_msg_tick (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clear(mid_sync),
		.tick(msg_tick)
	);

	assign op = bc_seq_pkg::opcode_t'(op_decoded);
	assign host_flag_wr = reg_wr && reg_addr == `REG_COND_CODES;
	assign start_req = reg_wr && reg_addr == `REG_MASTER_CFG1 &&
		reg_wdata[`CFG_START_POS];

	// host write to flag register: high byte clears, low byte sets;
	// both set means toggle
	always_comb begin
		host_mask = 8'h00;
		flag_src = flags_ff;
		if (host_flag_wr) begin
			for (int i = 0; i < 8; i++) begin
				if (reg_wdata[i] && reg_wdata[i + 8]) begin
					flag_src[i] = ~flags_ff[i];
				end else if (reg_wdata[i]) begin
					flag_src[i] = 1'b1;
				end else if (reg_wdata[i + 8]) begin
					flag_src[i] = 1'b0;
				end
			end
			host_mask = reg_wdata[7:0] | reg_wdata[15:8];
		end
	end

	always_comb begin
		nxt_list_start = list_start_ff;
		nxt_list_ptr = list_ptr_ff;
		nxt_frame = frame_ff;
		nxt_frame_run = frame_run_ff;
		nxt_next_msg = next_msg_ff;
		nxt_next_msg_pend = next_msg_pend_ff;
		nxt_flags = flag_src;
		nxt_upper = upper_ff;
		nxt_enable = enable_ff;
		nxt_run = run_ff;
		nxt_opword = opword_ff;
		nxt_param = param_ff;
		nxt_state = state_ff;
		nxt_ram_addr = ram_addr_ff;
		nxt_ram_rd = 1'b0;
		nxt_msg_start = 1'b0;
		nxt_trap = 1'b0;
		nxt_rdata = rdata_ff;

		if (reg_wr && reg_addr == `REG_LIST_START) begin
			nxt_list_start = reg_wdata;
		end
		if (reg_wr && reg_addr == `REG_MASTER_CFG1) begin
			nxt_enable = reg_wdata[`CFG_ENABLE_POS];
		end

		// frame countdown holds at zero; no wrap
		if (frame_run_ff && frame_tick && frame_ff != 16'h0000) begin
			nxt_frame = frame_ff - 16'h0001;
		end
		// host write after the countdown so a tick cannot swallow it
		if (reg_wr && reg_addr == `REG_FRAME_TIME) begin
			nxt_frame = reg_wdata;
		end
		if (next_msg_ff != 16'h0000 && msg_tick) begin
			nxt_next_msg = next_msg_ff - 16'h0001;
		end
		if (mid_sync) begin
			nxt_next_msg = next_msg_pend_ff;
		end
		if (msg_done) begin
			nxt_next_msg_pend = msg_word4;
			nxt_upper[`CC_RETRY_HI - 8:`CC_RETRY_LO - 8] =
				(msg_retries == 2'b11) ? 2'b10 : msg_retries;
			nxt_upper[`CC_FAILED_MESSAGE_FLAG_POS - 8] = msg_bad;
			// results fill cc 11:8 only; bit 12 belongs to the bad flag
			nxt_upper[3:0] = msg_results[3:0];
		end

		case (state_ff)
			bc_seq_pkg::st_idle: begin
				if (start_req && (reg_wdata[`CFG_ENABLE_POS] || enable_ff)) begin
					nxt_run = 1'b1;
					nxt_list_ptr = list_start_ff;
					nxt_ram_addr = list_start_ff;
					nxt_ram_rd = 1'b1;
					nxt_state = bc_seq_pkg::st_fetch_op;
				end
			end
			bc_seq_pkg::st_fetch_op: begin
				// request stays up until the word arrives
				nxt_ram_rd = !ram_valid;
				if (ram_valid) begin
					nxt_opword = ram_rdata;
					nxt_ram_addr = list_ptr_ff + 16'h0001;
					nxt_ram_rd = 1'b1;
					nxt_state = bc_seq_pkg::st_fetch_par;
				end
			end
			bc_seq_pkg::st_fetch_par: begin
				nxt_ram_rd = !ram_valid;
				if (ram_valid) begin
					nxt_param = ram_rdata;
					nxt_state = bc_seq_pkg::st_exec;
				end
			end
			bc_seq_pkg::st_exec: begin
				nxt_list_ptr = list_ptr_ff + `INSTR_STEP;
				nxt_state = bc_seq_pkg::st_fetch_op;
				case (op)
					bc_seq_pkg::op_halt: begin
						nxt_run = 1'b0;
					end
					bc_seq_pkg::op_jump: begin
						if (cond_true) begin
							nxt_list_ptr = jump_target;
						end
					end
					bc_seq_pkg::op_load_frame: begin
						nxt_frame = param_ff;
					end
					bc_seq_pkg::op_start_frame: begin
						nxt_frame_run = 1'b1;
					end
					bc_seq_pkg::op_flag: begin
						for (int i = 0; i < 8; i++) begin
							// host write wins on a bit it touches this cycle
							if (flag_mask[i] && !host_mask[i]) begin
								case (bc_seq_pkg::flag_mode_t'(flag_mode))
									bc_seq_pkg::flag_set: nxt_flags[i] = 1'b1;
									bc_seq_pkg::flag_clear: nxt_flags[i] = 1'b0;
									bc_seq_pkg::flag_toggle: nxt_flags[i] = ~flags_ff[i];
									default: nxt_flags[i] = flags_ff[i];
								endcase
							end
						end
					end
					bc_seq_pkg::op_cmp_frame: begin
						if (!host_mask[1]) begin
							nxt_flags[1] = frame_ff < param_ff;
						end
						if (!host_mask[0]) begin
							nxt_flags[0] = frame_ff == param_ff;
						end
					end
					bc_seq_pkg::op_cmp_msg: begin
						if (!host_mask[1]) begin
							nxt_flags[1] = next_msg_ff < param_ff;
						end
						if (!host_mask[0]) begin
							nxt_flags[0] = next_msg_ff == param_ff;
						end
					end
					bc_seq_pkg::op_message: begin
						// step deferred until the message outcome is known
						nxt_list_ptr = list_ptr_ff;
						nxt_msg_start = 1'b1;
						nxt_state = bc_seq_pkg::st_wait_msg;
					end
					bc_seq_pkg::op_nop: begin
					end
					default: begin
						nxt_run = 1'b0;
						nxt_trap = trap_enable;
					end
				endcase
				if (!nxt_run) begin
					nxt_state = bc_seq_pkg::st_idle;
				end else if (nxt_state == bc_seq_pkg::st_fetch_op) begin
					nxt_ram_addr = nxt_list_ptr;
					nxt_ram_rd = 1'b1;
				end
			end
			bc_seq_pkg::st_wait_msg: begin
				// pointer step waits for message outcome
				if (msg_done) begin
					nxt_list_ptr = list_ptr_ff + `INSTR_STEP;
					nxt_ram_addr = list_ptr_ff + `INSTR_STEP;
					nxt_ram_rd = 1'b1;
					nxt_state = bc_seq_pkg::st_fetch_op;
				end
			end
			default: begin
				nxt_state = bc_seq_pkg::st_idle;
			end
		endcase

		// clearing enable stops the run from any state
		if (reg_wr && reg_addr == `REG_MASTER_CFG1 &&
			!reg_wdata[`CFG_ENABLE_POS]) begin
			nxt_run = 1'b0;
			nxt_ram_rd = 1'b0;
			nxt_state = bc_seq_pkg::st_idle;
		end

		if (reg_rd) begin
			case (reg_addr)
				`REG_LIST_START: nxt_rdata = list_start_ff;
				`REG_LIST_PTR: nxt_rdata = list_ptr_ff;
				`REG_FRAME_TIME: nxt_rdata = frame_ff;
				`REG_NEXT_MSG: nxt_rdata = next_msg_ff;
				`REG_COND_CODES: nxt_rdata = {run_ff, upper_ff[6:0], flags_ff};
				default: nxt_rdata = `RST_WORD;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			list_start_ff <= `RST_WORD;
			list_ptr_ff <= `RST_WORD;
			frame_ff <= `RST_WORD;
			frame_run_ff <= 1'b0;
			next_msg_ff <= `RST_WORD;
			next_msg_pend_ff <= `RST_WORD;
			flags_ff <= 8'h00;
			upper_ff <= 8'h00;
			enable_ff <= 1'b0;
			run_ff <= 1'b0;
			opword_ff <= `RST_WORD;
			param_ff <= `RST_WORD;
			rdata_ff <= `RST_WORD;
			ram_addr_ff <= `RST_WORD;
			ram_rd_ff <= 1'b0;
			msg_start_ff <= 1'b0;
			trap_ff <= 1'b0;
			state_ff <= bc_seq_pkg::st_idle;
		end else begin
			list_start_ff <= nxt_list_start;
			list_ptr_ff <= nxt_list_ptr;
			frame_ff <= nxt_frame;
			frame_run_ff <= nxt_frame_run;
			next_msg_ff <= nxt_next_msg;
			next_msg_pend_ff <= nxt_next_msg_pend;
			flags_ff <= nxt_flags;
			upper_ff <= nxt_upper;
			enable_ff <= nxt_enable;
			run_ff <= nxt_run;
			opword_ff <= nxt_opword;
			param_ff <= nxt_param;
			rdata_ff <= nxt_rdata;
			ram_addr_ff <= nxt_ram_addr;
			ram_rd_ff <= nxt_ram_rd;
			msg_start_ff <= nxt_msg_start;
			trap_ff <= nxt_trap;
			state_ff <= nxt_state;
		end
	end

	assign reg_rdata = rdata_ff;
	assign ram_addr = ram_addr_ff;
	assign ram_rd = ram_rd_ff;
	assign msg_start = msg_start_ff;
	assign illegal_opcode_trap_irq = trap_ff;
endmodule

// ---- include/bc_seq_params.svh ----
`ifndef BC_SEQ_PARAMS_SVH
`define BC_SEQ_PARAMS_SVH

`define REG_MASTER_CFG1 8'h00
`define REG_LIST_START 8'h33
`define REG_LIST_PTR 8'h34
`define REG_FRAME_TIME 8'h35
`define REG_NEXT_MSG 8'h36
`define REG_COND_CODES 8'h37

`define CFG_START_POS 13
`define CFG_ENABLE_POS 12
`define CC_RUN_POS 15
`define CC_RETRY_HI 14
`define CC_RETRY_LO 13
`define CC_FAILED_MESSAGE_FLAG_POS 12

`define RST_WORD 16'h0000
`define INSTR_STEP 16'h0002

`define CLK_MHZ 50
`define FRAME_TICK_US 100
`define MSG_TICK_US 1
`define FRAME_TICK_CYC (`FRAME_TICK_US * `CLK_MHZ)
`define MSG_TICK_CYC (`MSG_TICK_US * `CLK_MHZ)

`endif

// ---- include/bc_seq_pkg.sv ----
package bc_seq_pkg;
	typedef enum logic [3:0] {
		op_halt,
		op_jump,
		op_load_frame,
		op_start_frame,
		op_flag,
		op_cmp_frame,
		op_cmp_msg,
		op_message,
		op_nop,
		op_illegal
	} opcode_t;

	typedef enum logic [1:0] {
		flag_set,
		flag_clear,
		flag_toggle,
		flag_keep
	} flag_mode_t;

	typedef enum {
		st_idle,
		st_fetch_op,
		st_fetch_par,
		st_exec,
		st_wait_msg
	} seq_state_t;
endpackage

// ---- rtl/tick_divider.sv ----
`timescale 1ns/1ps
`include "bc_seq_params.svh"

module tick_divider #(
	parameter int unsigned DIV = 50
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clear,
	output logic tick
);
	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	logic tick_ff;
	logic nxt_tick;

	always_comb begin
		nxt_cnt = cnt_ff + 16'h0001;
		nxt_tick = 1'b0;
		if (clear) begin
			nxt_cnt = 16'h0000;
		end else if (cnt_ff == 16'(DIV - 1)) begin
			nxt_cnt = 16'h0000;
			nxt_tick = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 16'h0000;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign tick = tick_ff;
endmodule

// ---- test/bc_seq_regs_monitor.sv ----
`timescale 1ns/1ps
module bc_seq_regs_monitor (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic [15:0] ram_addr,
	input wire logic ram_rd,
	input wire logic ram_valid,
	input wire logic [3:0] op_decoded,
	input wire logic trap_enable,
	input wire logic msg_done,
	input wire logic msg_bad,
	input wire logic illegal_opcode_trap_irq
);
	logic [15:0] start_ff;
	logic [15:0] nxt_start;
	// shadow of the list base, taken from host writes
	assign nxt_start = (reg_wr && reg_addr == 8'h33) ? reg_wdata : start_ff;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			start_ff <= 16'h0000;
		end else begin
			start_ff <= nxt_start;
		end
	end
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	property p_start_load;
		reg_wr && reg_addr == 8'h00 && reg_wdata[13:12] == 2'b11 && !ram_rd
		|=> ram_rd && ram_addr == start_ff;
	endproperty
	a_start_load: assert property (p_start_load)
		else $error("start did not fetch from list base");
	// a host write in the same cycle may stop the run, so it is excluded
	property p_pair;
		ram_rd && ram_valid && !ram_addr[0] && !reg_wr
		|=> ram_addr == $past(ram_addr) + 16'h0001;
	endproperty
	a_pair: assert property (p_pair)
		else $error("parameter word not fetched after op word");
	property p_trap;
		illegal_opcode_trap_irq |-> $past(trap_enable)
		&& $past(op_decoded) > 4'h8 ##1 !illegal_opcode_trap_irq;
	endproperty
	a_trap: assert property (p_trap)
		else $error("trap pulse without enabled illegal op");
	property p_trap_stop;
		illegal_opcode_trap_irq |-> !ram_rd [*4];
	endproperty
	a_trap_stop: assert property (p_trap_stop)
		else $error("fetching continued after illegal op");
	property p_run_bit;
		reg_rd && reg_addr == 8'h37 && ram_rd |=> reg_rdata[15];
	endproperty
	a_run_bit: assert property (p_run_bit)
		else $error("run bit low while fetching");
	property p_retry_code;
		reg_rd && reg_addr == 8'h37 |=> reg_rdata[14:13] != 2'b11;
	endproperty
	a_retry_code: assert property (p_retry_code)
		else $error("retry code 11 reported");
	property p_bad_msg;
		msg_done && msg_bad ##2 reg_rd && reg_addr == 8'h37 |=> reg_rdata[12];
	endproperty
	a_bad_msg: assert property (p_bad_msg)
		else $error("failed message bit not reported");
	property p_flag_set;
		reg_wr && reg_addr == 8'h37 && reg_wdata == 16'h00ff
		##2 reg_rd && reg_addr == 8'h37 |=> reg_rdata[7:0] == 8'hff;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("host flag set not seen");
endmodule
bind bc_sequencer_regs bc_seq_regs_monitor i_mon (.ref_clk(ref_clk),
	.rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ram_addr(ram_addr),
	.ram_rd(ram_rd), .ram_valid(ram_valid), .op_decoded(op_decoded),
	.trap_enable(trap_enable), .msg_done(msg_done), .msg_bad(msg_bad),
	.illegal_opcode_trap_irq(illegal_opcode_trap_irq));

// ---- test/instr_ram_model.sv ----
`timescale 1ns/1ps
module instr_ram_model (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [15:0] ram_addr,
	input wire logic ram_rd,
	output logic ram_valid,
	output logic [15:0] ram_rdata,
	output logic [3:0] op_decoded,
	output logic [15:0] jump_target
);
	logic [15:0] mem [0:255];
	logic [15:0] fetch_log [$];
	logic [1:0] wait_cnt;
	logic slow;
	// answers alternate prompt and slow so both wait paths run
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ram_valid <= 1'b0;
			ram_rdata <= 16'h0000;
			op_decoded <= 4'h8;
			jump_target <= 16'h0000;
			wait_cnt <= 2'h0;
			slow <= 1'b0;
		end else begin
			ram_valid <= 1'b0;
			// released data bus never keeps the last word
			ram_rdata <= ~ram_rdata;
			if (ram_rd && !ram_valid) begin
				if (wait_cnt == {slow, slow}) begin
					ram_valid <= 1'b1;
					ram_rdata <= mem[ram_addr[7:0]];
					fetch_log.push_back(ram_addr);
					wait_cnt <= 2'h0;
					slow <= ~slow;
					if (ram_addr[0]) begin
						jump_target <= mem[ram_addr[7:0]];
					end else begin
						op_decoded <= mem[ram_addr[7:0]][3:0];
					end
				end else begin
					wait_cnt <= wait_cnt + 2'h1;
				end
			end else if (!ram_rd) begin
				// a dropped request leaves no wait count behind
				wait_cnt <= 2'h0;
			end
		end
	end
endmodule

// ---- test/bc_sequencer_regs_tb.sv ----
`timescale 1ns/1ps
module bc_sequencer_regs_tb;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata, ram_addr, ram_rdata, jump_target;
	logic ram_rd, ram_valid, msg_start, illegal_opcode_trap_irq;
	logic [3:0] op_decoded;
	logic cond_true = 1'b1;
	logic msg_done = 1'b0;
	logic [1:0] msg_retries = 2'h0;
	logic msg_bad = 1'b0;
	logic trap_enable = 1'b0;
	logic [1:0] flag_mode = 2'h3;
	logic [7:0] flag_mask = 8'h00;
	logic mid_sync = 1'b0;
	logic [15:0] msg_word4 = 16'h0000;
	logic [4:0] msg_results = 5'h00;
	int n_fail = 0;
	int n_compared = 0;
	int n_trap = 0;
	int n_msg = 0;
	int cycles = 0;
	always #10 ref_clk = ~ref_clk;
	bc_sequencer_regs i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ram_addr(ram_addr),
		.ram_rd(ram_rd), .ram_valid(ram_valid), .ram_rdata(ram_rdata),
		.op_decoded(op_decoded), .jump_target(jump_target),
		.cond_true(cond_true), .flag_mode(flag_mode),
		.flag_mask(flag_mask),
		.msg_done(msg_done), .msg_retries(msg_retries), .msg_bad(msg_bad),
		.msg_results(msg_results), .mid_sync(mid_sync),
		.msg_word4(msg_word4),
		.trap_enable(trap_enable), .msg_start(msg_start),
		.illegal_opcode_trap_irq(illegal_opcode_trap_irq));
	instr_ram_model i_ram (.ref_clk(ref_clk), .rst_n(rst_n),
		.ram_addr(ram_addr), .ram_rd(ram_rd), .ram_valid(ram_valid),
		.ram_rdata(ram_rdata), .op_decoded(op_decoded),
		.jump_target(jump_target));
	task automatic stop_test();
		if (n_fail == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (illegal_opcode_trap_irq === 1'b1) n_trap++;
		if (msg_start === 1'b1) n_msg++;
		if (cycles == 20000) begin
			n_fail++;
			stop_test();
		end
	end
	task automatic chk(input string what, input logic [15:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, logic [15:0] exp, string what);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(what, reg_rdata, exp);
	endtask
	task automatic prog(input logic [7:0] a, logic [15:0] op, par);
		i_ram.mem[a] = op;
		i_ram.mem[a + 8'h01] = par;
	endtask
	// bounded wait on fetches, then a short settle for the last op
	task automatic run_from(input logic [15:0] base, input int n);
		i_ram.fetch_log.delete();
		wr(8'h33, base);
		wr(8'h00, 16'h3000);
		for (int i = 0; i < 300 && i_ram.fetch_log.size() < n; i++) begin
			@(posedge ref_clk);
		end
		repeat (8) @(posedge ref_clk);
	endtask
	task automatic t_reset();
		rd(8'h36, 16'h0000, "next msg at reset");
		rd(8'h37, 16'h0000, "cc at reset");
		rd(8'h40, 16'h0000, "unmapped read");
	endtask
	task automatic t_flags();
		wr(8'h37, 16'h00ff);
		rd(8'h37, 16'h00ff, "flags set");
		wr(8'h37, 16'h0303);
		rd(8'h37, 16'h00fc, "flags toggled");
		wr(8'h37, 16'hff00);
		rd(8'h37, 16'h0000, "flags cleared");
	endtask
	task automatic t_list();
		logic [15:0] exp_log [6];
		exp_log = '{16'h0010, 16'h0011, 16'h0012, 16'h0013, 16'h0020, 16'h0021};
		prog(8'h10, 16'h0002, 16'h0005);
		prog(8'h12, 16'h0001, 16'h0020);
		prog(8'h20, 16'h0000, 16'h0000);
		run_from(16'h0010, 6);
		chk("fetches", 16'(i_ram.fetch_log.size()), 16'h0006);
		foreach (exp_log[i]) chk("fetch", i_ram.fetch_log[i], exp_log[i]);
		rd(8'h35, 16'h0005, "frame time");
		rd(8'h37, 16'h0000, "cc after halt");
	endtask
	task automatic t_trap();
		@(posedge ref_clk);
		trap_enable <= 1'b1;
		prog(8'h30, 16'h0009, 16'h0000);
		n_trap = 0;
		run_from(16'h0030, 2);
		chk("trap pulses", 16'(n_trap), 16'h0001);
		rd(8'h37, 16'h0000, "cc after trap");
	endtask
	task automatic t_stop();
		prog(8'h40, 16'h0001, 16'h0040);
		run_from(16'h0040, 8);
		rd(8'h37, 16'h8000, "cc running");
		wr(8'h34, 16'h1234);
		rd(8'h34, 16'h0040, "list pointer");
		wr(8'h00, 16'h0000);
		rd(8'h37, 16'h0000, "cc stopped");
	endtask
	task automatic pulse_msg(input logic [1:0] r, input logic b);
		@(posedge ref_clk);
		msg_done <= 1'b1;
		msg_retries <= r;
		msg_bad <= b;
		@(posedge ref_clk);
		msg_done <= 1'b0;
	endtask
	task automatic t_msg();
		pulse_msg(2'h3, 1'b1);
		rd(8'h37, 16'h5000, "retries saturate");
		pulse_msg(2'h1, 1'b0);
		rd(8'h37, 16'h2000, "one retry");
		pulse_msg(2'h2, 1'b0);
		rd(8'h37, 16'h4000, "two retries");
	endtask
	task automatic t_ops();
		prog(8'h50, 16'h0002, 16'h0003);
		prog(8'h52, 16'h0003, 16'h0000);
		prog(8'h54, 16'h0004, 16'h0000);
		prog(8'h56, 16'h0005, 16'h0003);
		prog(8'h58, 16'h0007, 16'h0000);
		prog(8'h5a, 16'h0000, 16'h0000);
		@(posedge ref_clk);
		flag_mode <= 2'h0;
		flag_mask <= 8'h80;
		msg_results <= 5'h0a;
		msg_word4 <= 16'h0005;
		run_from(16'h0050, 10);
		chk("message starts", 16'(n_msg), 16'h0001);
		rd(8'h34, 16'h0058, "pointer holds for message");
		pulse_msg(2'h0, 1'b0);
		repeat (16) @(posedge ref_clk);
		chk("fetch after message", i_ram.fetch_log[10], 16'h005a);
		rd(8'h37, 16'h0a81, "cc after ops");
		@(posedge ref_clk);
		mid_sync <= 1'b1;
		@(posedge ref_clk);
		mid_sync <= 1'b0;
		rd(8'h36, 16'h0005, "next msg loaded");
		repeat (120) @(posedge ref_clk);
		rd(8'h36, 16'h0003, "next msg count");
		rd(8'h35, 16'h0003, "frame before tick");
		repeat (7300) @(posedge ref_clk);
		rd(8'h35, 16'h0002, "frame after tick");
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset();
		t_flags();
		t_list();
		t_trap();
		t_stop();
		t_msg();
		t_ops();
		stop_test();
	end
endmodule
